// ==== verilog/ussmt_top.sv ====
// Overview of operation
// - half duplex; receive blocked while transmitting
// - sync select bit 4 selects synchronous
// - port enable bit 7 makes clock/data pins
// - clock source bit 7 drives clock line
// - shifter reloads only after last bit sent
// - one-cycle move, buffer empty, flag set
// - tx interrupt enable bit 4 masks request
// - flag set always; cleared only by load (a load in the move cycle leaves the flag set)
// - read-only shifter empty status at bit 1
// - shifter empty raises no interrupt
// - shift register not software accessible
// - nine-bit mode sends ninth bit too
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
module ussmt_top
  import ussmt_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clock_line_in,
  output logic serial_clock_line_out,
  output logic serial_clock_line_oe_n,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe_n,
  output logic rx_inhibit,
  output logic irq
);
  logic [7:0] tx_control_status_reg, tx_control_status_next;
  logic [7:0] rx_control_status_reg, rx_control_status_next;
  logic [7:0] baud_divisor_reg, baud_divisor_next;
  logic [7:0] peripheral_enable_reg1_reg, peripheral_enable_reg1_next;
  logic [7:0] interrupt_control_reg_reg, interrupt_control_reg_next;
  logic [8:0] tx_holding_buffer_reg, tx_holding_buffer_next;
  logic holding_full_reg, holding_full_next;
  logic tx_buffer_empty_flag_reg, tx_buffer_empty_flag_next;
  logic [8:0] tx_shift_register_reg, tx_shift_register_next;
  logic [3:0] bits_left_reg, bits_left_next;
  ussmt_state_e state_reg, state_next;
  ussmt_pins_s pins_reg, pins_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next, irq_next, rx_inhibit_next;
  logic [2:0] ck_sync_reg, dt_sync_reg;
  logic apb_access, apb_write, apb_read, holding_write;
  logic master_on, tick, shifter_busy;

  // link inputs are unused in master transmit; synchronised for future receive use
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ck_sync_reg <= 3'h0;
      dt_sync_reg <= 3'h0;
    end else begin
      ck_sync_reg <= {ck_sync_reg[1:0], serial_clock_line_in};
      dt_sync_reg <= {dt_sync_reg[1:0], serial_data_line_in};
    end
  end

  assign apb_access = psel && penable && pready;
  assign apb_write = apb_access && pwrite;
  assign apb_read = apb_access && !pwrite;
  assign holding_write = apb_write && (paddr == TX_HOLDING_BUFFER_OFS);
  assign master_on = tx_control_status_reg[TXCS_SYNC_SELECT]
    && rx_control_status_reg[RXCS_SERIAL_PORT_ENABLE]
    && tx_control_status_reg[TXCS_CLOCK_SOURCE]
    && tx_control_status_reg[TXCS_TX_ENABLE];
  assign shifter_busy = (state_reg != USSMT_IDLE);

  ussmt_baud_gen #(.DIV_W(DIV_W)) u_baud (
    .core_clk(core_clk),
    .resetn(resetn),
    .run(shifter_busy && state_reg != USSMT_LOAD),
    .divisor(baud_divisor_reg[DIV_W-1:0]),
    .tick(tick)
  );

  // register file
  always_comb begin
    tx_control_status_next = tx_control_status_reg;
    rx_control_status_next = rx_control_status_reg;
    baud_divisor_next = baud_divisor_reg;
    peripheral_enable_reg1_next = peripheral_enable_reg1_reg;
    interrupt_control_reg_next = interrupt_control_reg_reg;
    prdata_next = 32'h0;
    pslverr_next = 1'b0;
    pready_next = psel && !penable;
    if (apb_write) begin
      case (paddr)
        TX_CONTROL_STATUS_OFS: tx_control_status_next = pwdata[7:0];
        RX_CONTROL_STATUS_OFS: rx_control_status_next = pwdata[7:0];
        BAUD_DIVISOR_OFS: baud_divisor_next = pwdata[7:0];
        PERIPHERAL_ENABLE_REG1_OFS: peripheral_enable_reg1_next = pwdata[7:0];
        INTERRUPT_CONTROL_OFS: interrupt_control_reg_next = pwdata[7:0];
        TX_HOLDING_BUFFER_OFS, PERIPHERAL_FLAG_REG1_OFS: ;
        default: ;
      endcase
    end
    // shifter empty is hardware status, write ignored
    tx_control_status_next[TXCS_SHIFTER_EMPTY] = !shifter_busy;
    tx_control_status_next[3:2] = 2'h0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        TX_CONTROL_STATUS_OFS: prdata_next = {24'h0, tx_control_status_reg};
        RX_CONTROL_STATUS_OFS: prdata_next = {24'h0, rx_control_status_reg};
        TX_HOLDING_BUFFER_OFS: prdata_next = {24'h0, tx_holding_buffer_reg[7:0]};
        BAUD_DIVISOR_OFS: prdata_next = {24'h0, baud_divisor_reg};
        PERIPHERAL_FLAG_REG1_OFS: prdata_next = {27'h0, tx_buffer_empty_flag_reg, 4'h0};
        PERIPHERAL_ENABLE_REG1_OFS: prdata_next = {24'h0, peripheral_enable_reg1_reg};
        INTERRUPT_CONTROL_OFS: prdata_next = {24'h0, interrupt_control_reg_reg};
        default: pslverr_next = 1'b1; // no shift register address exists
      endcase
    end else if (psel && !penable) begin
      case (paddr)
        TX_CONTROL_STATUS_OFS, RX_CONTROL_STATUS_OFS, TX_HOLDING_BUFFER_OFS, BAUD_DIVISOR_OFS,
        PERIPHERAL_FLAG_REG1_OFS, PERIPHERAL_ENABLE_REG1_OFS, INTERRUPT_CONTROL_OFS: ;
        default: pslverr_next = 1'b1;
      endcase
    end
  end

  // holding buffer, flag and shifter
  always_comb begin
    tx_holding_buffer_next = tx_holding_buffer_reg;
    holding_full_next = holding_full_reg;
    tx_buffer_empty_flag_next = tx_buffer_empty_flag_reg;
    tx_shift_register_next = tx_shift_register_reg;
    bits_left_next = bits_left_reg;
    state_next = state_reg;
    pins_next = pins_reg;
    // ninth bit is sampled with the data so a late mode change cannot split a word
    if (holding_write) begin
      tx_holding_buffer_next = {tx_control_status_reg[TXCS_NINTH_BIT], pwdata[7:0]};
      holding_full_next = 1'b1;
      tx_buffer_empty_flag_next = 1'b0;
    end
    case (state_reg)
      USSMT_IDLE: begin
        if (holding_full_reg && master_on) begin
          state_next = USSMT_LOAD;
        end
      end
      USSMT_LOAD: begin
        // single-cycle move; a same-cycle reload of the buffer keeps new data
        tx_shift_register_next = tx_holding_buffer_reg;
        bits_left_next = tx_control_status_reg[TXCS_NINE_BIT_SELECT] ? 4'h9 : 4'h8;
        if (!holding_write) begin
          holding_full_next = 1'b0;
        end
        tx_buffer_empty_flag_next = 1'b1;
        pins_next.data_out = tx_holding_buffer_reg[0];
        state_next = USSMT_LOW;
      end
      USSMT_LOW: begin
        pins_next.clk_out = 1'b0;
        if (tick) begin
          pins_next.clk_out = 1'b1; // slave samples on rising edge
          state_next = USSMT_HIGH;
        end
      end
      USSMT_HIGH: begin
        if (tick) begin
          pins_next.clk_out = 1'b0;
          tx_shift_register_next = {1'b0, tx_shift_register_reg[8:1]};
          bits_left_next = bits_left_reg - 4'h1;
          pins_next.data_out = tx_shift_register_reg[1];
          if (bits_left_reg == 4'h1) begin
            // reload only once the last bit is out
            if (holding_full_next && master_on) begin
              state_next = USSMT_LOAD;
            end else begin
              state_next = USSMT_IDLE;
            end
          end else begin
            state_next = USSMT_LOW;
          end
        end
      end
      default: state_next = USSMT_IDLE;
    endcase
    if (!master_on && state_reg == USSMT_IDLE) begin
      pins_next.clk_out = 1'b0;
    end
    pins_next.clk_oe_n = !(rx_control_status_reg[RXCS_SERIAL_PORT_ENABLE]
      && tx_control_status_reg[TXCS_CLOCK_SOURCE]);
    pins_next.data_oe_n = !(master_on && rx_control_status_reg[RXCS_SERIAL_PORT_ENABLE]);
  end

  // shifter empty is never fed to the interrupt
  assign irq_next = tx_buffer_empty_flag_reg
    && peripheral_enable_reg1_reg[PER1_TX_IRQ_ENABLE]
    && interrupt_control_reg_reg[INTERRUPT_CONTROL_REG_GLOBAL_IRQ]
    && interrupt_control_reg_reg[INTERRUPT_CONTROL_REG_PERIPH_IRQ];
  // transmitting blocks the receiver
  assign rx_inhibit_next = shifter_busy || holding_full_reg;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_control_status_reg <= TX_CONTROL_STATUS_RST;
      rx_control_status_reg <= RX_CONTROL_STATUS_RST;
      baud_divisor_reg <= BAUD_DIVISOR_RST;
      peripheral_enable_reg1_reg <= PERIPHERAL_ENABLE_RST;
      interrupt_control_reg_reg <= INTERRUPT_CONTROL_RST;
      tx_holding_buffer_reg <= 9'h000;
      holding_full_reg <= 1'b0;
      tx_buffer_empty_flag_reg <= 1'b1;
      tx_shift_register_reg <= 9'h000;
      bits_left_reg <= 4'h0;
      state_reg <= USSMT_IDLE;
      pins_reg <= '{clk_out: 1'b0, clk_oe_n: 1'b1, data_out: 1'b0, data_oe_n: 1'b1};
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      rx_inhibit <= 1'b0;
    end else begin
      tx_control_status_reg <= tx_control_status_next;
      rx_control_status_reg <= rx_control_status_next;
      baud_divisor_reg <= baud_divisor_next;
      peripheral_enable_reg1_reg <= peripheral_enable_reg1_next;
      interrupt_control_reg_reg <= interrupt_control_reg_next;
      tx_holding_buffer_reg <= tx_holding_buffer_next;
      holding_full_reg <= holding_full_next;
      tx_buffer_empty_flag_reg <= tx_buffer_empty_flag_next;
      tx_shift_register_reg <= tx_shift_register_next;
      bits_left_reg <= bits_left_next;
      state_reg <= state_next;
      pins_reg <= pins_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
      irq <= irq_next;
      rx_inhibit <= rx_inhibit_next;
    end
  end

  assign serial_clock_line_out = pins_reg.clk_out;
  assign serial_clock_line_oe_n = pins_reg.clk_oe_n;
  assign serial_data_line_out = pins_reg.data_out;
  assign serial_data_line_oe_n = pins_reg.data_oe_n;
endmodule

// ==== verilog/ussmt_pkg.sv ====
package ussmt_pkg;
  // apb byte offsets
  localparam logic [7:0] TX_CONTROL_STATUS_OFS = 8'h00;
  localparam logic [7:0] RX_CONTROL_STATUS_OFS = 8'h04;
  localparam logic [7:0] TX_HOLDING_BUFFER_OFS = 8'h08;
  localparam logic [7:0] BAUD_DIVISOR_OFS = 8'h0c;
  localparam logic [7:0] PERIPHERAL_FLAG_REG1_OFS = 8'h10;
  localparam logic [7:0] PERIPHERAL_ENABLE_REG1_OFS = 8'h14;
  localparam logic [7:0] INTERRUPT_CONTROL_OFS = 8'h18;
  // field positions
  localparam int TXCS_NINTH_BIT = 0;
  localparam int TXCS_SHIFTER_EMPTY = 1;
  localparam int TXCS_SYNC_SELECT = 4;
  localparam int TXCS_TX_ENABLE = 5;
  localparam int TXCS_NINE_BIT_SELECT = 6;
  localparam int TXCS_CLOCK_SOURCE = 7;
  localparam int RXCS_SERIAL_PORT_ENABLE = 7;
  localparam int PFR1_TX_BUFFER_EMPTY = 4;
  localparam int PER1_TX_IRQ_ENABLE = 4;
  localparam int INTERRUPT_CONTROL_REG_GLOBAL_IRQ = 7;
  localparam int INTERRUPT_CONTROL_REG_PERIPH_IRQ = 6;
  // reset values
  localparam logic [7:0] TX_CONTROL_STATUS_RST = 8'h02;
  localparam logic [7:0] RX_CONTROL_STATUS_RST = 8'h00;
  localparam logic [7:0] BAUD_DIVISOR_RST = 8'h00;
  localparam logic [7:0] PERIPHERAL_ENABLE_RST = 8'h00;
  localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
  // one instruction cycle for the buffer to shifter move
  localparam int INSTRUCTION_CYCLE_CLKS = 1;

  typedef enum logic [1:0] {USSMT_IDLE, USSMT_LOAD, USSMT_LOW, USSMT_HIGH} ussmt_state_e;

  typedef struct packed {
    logic clk_out;
    logic clk_oe_n;
    logic data_out;
    logic data_oe_n;
  } ussmt_pins_s;
endpackage

// ==== verilog/ussmt_baud_gen.sv ====
`timescale 1ns/10ps
module ussmt_baud_gen
  import ussmt_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);
  // one pulse every divisor+1 cycles; held in reload while stopped
  logic [DIV_W-1:0] count_reg;
  logic [DIV_W-1:0] count_next;
  logic tick_next;

  always_comb begin
    count_next = count_reg;
    tick_next = 1'b0;
    if (!run) begin
      count_next = divisor;
    end else if (count_reg == '0) begin
      count_next = divisor;
      tick_next = 1'b1;
    end else begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
      tick <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick <= tick_next;
    end
  end
endmodule

// ==== sim/ussmt_asserts.sv ====
`timescale 1ns/10ps
module ussmt_asserts (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_clock_line_out,
  input wire logic serial_clock_line_oe_n,
  input wire logic serial_data_line_out,
  input wire logic rx_inhibit,
  input wire logic irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  AST_READY: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready too long");
  AST_IDLE: assert property (!psel |=> !pready) else $error("ready unselected");
  AST_ERR: assert property (pslverr |-> pready) else $error("error without ready");
  AST_CLK_DRIVEN: assert property ($rose(serial_clock_line_out) |-> !serial_clock_line_oe_n)
    else $error("clock not driven");
  AST_CLK_IN_TX: assert property ($rose(serial_clock_line_out) |-> rx_inhibit)
    else $error("clock while idle");
  AST_DATA_ON_FALL: assert property ($changed(serial_data_line_out) |-> !serial_clock_line_out)
    else $error("data moved with clock high");
  // only a software write (buffer load or enable change) may drop the request, never a shifter event
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(pready && pwrite) || $past(pready && pwrite, 2))
    else $error("irq fell without write");
  cover property (pslverr);
  cover property ($rose(serial_clock_line_out));
  cover property ($rose(irq));
endmodule

bind ussmt_top ussmt_asserts u_asserts (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .serial_clock_line_out(serial_clock_line_out),
  .serial_clock_line_oe_n(serial_clock_line_oe_n), .serial_data_line_out(serial_data_line_out),
  .rx_inhibit(rx_inhibit), .irq(irq));

// ==== sim/ussmt_slave.sv ====
`timescale 1ns/10ps
module ussmt_slave (
  input wire logic clk_line,
  input wire logic data_line,
  input wire logic clr,
  output logic [17:0] sr,
  output int bits,
  output realtime period
);
  realtime t_last = 0;
  initial begin
    sr = '0;
    bits = 0;
    period = 0;
  end
  // samples on the rising clock edge, lsb arrives first
  always @(posedge clk_line or posedge clr) begin
    if (clr) begin
      bits <= 0;
    end else begin
      sr <= {data_line, sr[17:1]};
      bits <= bits + 1;
      period <= $realtime - t_last;
      t_last <= $realtime;
    end
  end
endmodule

// ==== sim/ussmt_top_tb.sv ====
`timescale 1ns/10ps
module ussmt_top_tb;
  import ussmt_pkg::*;
  logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0, last_dt = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, ck_out, ck_oe_n, dt_out, dt_oe_n, rx_inhibit, irq, err;
  // released data line shows the inverse of its last value, clock idles low
  wire logic ck_w = !ck_oe_n ? ck_out : 1'b0;
  wire logic dt_w = !dt_oe_n ? dt_out : ~last_dt;
  logic [17:0] sr;
  int bits, errors = 0, total_checks = 0, cycles = 0;
  realtime period;
  initial forever #10 core_clk = ~core_clk;
  ussmt_top dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_line_in(ck_w), .serial_clock_line_out(ck_out), .serial_clock_line_oe_n(ck_oe_n),
    .serial_data_line_in(dt_w), .serial_data_line_out(dt_out), .serial_data_line_oe_n(dt_oe_n),
    .rx_inhibit(rx_inhibit), .irq(irq));
  ussmt_slave slave (.clk_line(ck_w), .data_line(dt_w), .clr(clr), .sr(sr), .bits(bits), .period(period));
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (!dt_oe_n) last_dt <= dt_out;
    if (cycles == 60000) begin
      errors++;
      finish_test();
    end
  end
  task finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    // waits for ready as long as it takes; only the bench timeout ends a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
    xfer(a, 0, 0);
    check(name, exp, rd);
  endtask
  task wait_bits(input int n);
    for (int i = 0; i < 5000 && bits < n; i++) @(posedge core_clk);
  endtask
  task wait_empty;
    for (int k = 0; k < 100; k++) begin
      xfer(TX_CONTROL_STATUS_OFS, 0, 0);
      if (rd[1] === 1'b1) break;
    end
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1;
    rdchk(TX_CONTROL_STATUS_OFS, 32'h02, "txcs reset");
    rdchk(PERIPHERAL_FLAG_REG1_OFS, 32'h10, "flag reset");
    check("pins released", 32'h3, {30'h0, ck_oe_n, dt_oe_n});
    xfer(8'h1c, 0, 0);
    check("unmapped", 32'h1, {31'h0, err});
    xfer(PERIPHERAL_FLAG_REG1_OFS, 1, 32'h0);
    rdchk(PERIPHERAL_FLAG_REG1_OFS, 32'h10, "flag write");
    xfer(BAUD_DIVISOR_OFS, 1, 32'h3);
    xfer(TX_CONTROL_STATUS_OFS, 1, 32'hb0);
    xfer(RX_CONTROL_STATUS_OFS, 1, 32'h80);
    xfer(PERIPHERAL_ENABLE_REG1_OFS, 1, 32'h10);
    xfer(INTERRUPT_CONTROL_OFS, 1, 32'hc0);
    repeat (3) @(posedge core_clk);
    check("irq on", 32'h1, {31'h0, irq});
    check("pins driven", 32'h0, {30'h0, ck_oe_n, dt_oe_n});
    xfer(PERIPHERAL_ENABLE_REG1_OFS, 1, 32'h0);
    repeat (3) @(posedge core_clk);
    check("irq masked", 32'h0, {31'h0, irq});
    xfer(PERIPHERAL_ENABLE_REG1_OFS, 1, 32'h10);
    xfer(TX_HOLDING_BUFFER_OFS, 1, 32'ha5);
    xfer(TX_HOLDING_BUFFER_OFS, 1, 32'h3c);
    rdchk(PERIPHERAL_FLAG_REG1_OFS, 32'h0, "flag full");
    check("irq full", 32'h0, {31'h0, irq});
    rdchk(TX_CONTROL_STATUS_OFS, 32'hb0, "shifting");
    check("rx inhibit", 32'h1, {31'h0, rx_inhibit});
    wait_bits(9);
    rdchk(PERIPHERAL_FLAG_REG1_OFS, 32'h10, "flag reload");
    wait_bits(16);
    check("period", 32'd160, int'(period));
    check("words", 32'h3ca5, {16'h0, sr[17:2]});
    wait_empty();
    check("txcs empty", 32'hb2, rd);
    check("irq empty", 32'h1, {31'h0, irq});
    check("rx free", 32'h0, {31'h0, rx_inhibit});
    clr <= 1;
    @(posedge core_clk);
    clr <= 0;
    xfer(TX_CONTROL_STATUS_OFS, 1, 32'hf1);
    xfer(TX_HOLDING_BUFFER_OFS, 1, 32'h5a);
    wait_bits(9);
    check("nine bits", 32'h15a, {23'h0, sr[17:9]});
    wait_empty();
    finish_test();
  end
endmodule
